// ===== logic/bbs_pkg.sv
// Constants and types of the buck-boost setpoint register.
// Assumes an 8-bit register port and a 50 MHz system clock.
package bbs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] SETPOINT_ADDR = 8'h19;
	localparam logic [7:0] SETPOINT_RESET = 8'hB2;
	localparam int SKIP_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int CODE_MSB = 5;
	localparam int CODE_W = 6;
	localparam logic [5:0] CODE_DEFAULT = 6'h32;
	localparam logic [5:0] CODE_FINE_LAST = 6'h0F;
	localparam logic [5:0] CODE_LAST_VALID = 6'h34;
	localparam logic [15:0] MV_BASE = 16'h0497;
	localparam logic [15:0] MV_FINE_STEP = 16'h0019;
	localparam logic [15:0] MV_COARSE_STEP = 16'h0032;
	localparam logic [15:0] MV_FINE_TOP = 16'h060E;
	localparam int CLK_HZ = 50000000;
	localparam int BLANK_MS = 5;
	localparam int BLANK_CYCLES = CLK_HZ / 1000 * BLANK_MS;
	localparam int STATUS_ADDR_INT = 8'h1C;
	localparam logic [7:0] STATUS_ADDR = 8'h1C;
	localparam int ST_BLANK_BIT = 0;
	localparam int ST_RSVD_BIT = 1;
	localparam int ST_LOCK_BIT = 2;
	typedef enum logic [0:0] {
		BLK_IDLE = 1'b0,
		BLK_HOLD = 1'b1
	} bbs_blank_state_t;
endpackage : bbs_pkg

// ===== logic/bbs_blank_timer.sv
// Monitoring blanking timer: a start pulse holds blanking for a fixed count.
// Assumes one clock; a new start restarts the full interval.
`timescale 1ns/100ps
module bbs_blank_timer #(
	parameter int COUNT = bbs_pkg::BLANK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	output logic blanking
);
	import bbs_pkg::*;
	localparam int CW = $clog2(COUNT + 1);
	if (COUNT < 1) begin : gBadCount
		$error("COUNT must be at least one");
	end
	typedef struct packed {
		bbs_blank_state_t state;
		logic [CW-1:0] cnt;
	} bbs_timer_st_t;
	bbs_timer_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		if (start) begin
			st_next.state = BLK_HOLD;
			st_next.cnt = CW'(COUNT - 1);
		end else begin
			unique case (st_reg.state)
				BLK_IDLE: st_next.cnt = '0;
				BLK_HOLD: begin
					if (st_reg.cnt == '0) st_next.state = BLK_IDLE;
					else st_next.cnt = st_reg.cnt - CW'(1);
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) st_reg <= '{BLK_IDLE, '0};
		else st_reg <= st_next;
	end
	assign blanking = (st_reg.state == BLK_HOLD);
endmodule : bbs_blank_timer

// ===== logic/bbs_code_map.sv
// Maps a voltage code to millivolts and flags the reserved range.
// Pure combinational; the caller registers the results.
`timescale 1ns/100ps
module bbs_code_map (
	input wire logic [bbs_pkg::CODE_W-1:0] code,
	output logic [15:0] millivolts,
	output logic reserved
);
	import bbs_pkg::*;
	always_comb begin
		reserved = (code > CODE_LAST_VALID);
		if (code <= CODE_FINE_LAST)
			millivolts = 16'(MV_BASE + 16'(code) * MV_FINE_STEP);
		else if (!reserved)
			millivolts = 16'(MV_FINE_TOP + 16'(code - CODE_FINE_LAST) * MV_COARSE_STEP);
		else
			millivolts = '0;
	end
endmodule : bbs_code_map

// ===== logic/bbs_setpoint.sv
// Buck-boost converter setpoint register with write protection and monitor blanking.
// Assumes a same-clock register port and an unlock level from the password logic.
//
// What this block does
// [RQ1] The setpoint register sits at address 19h and resets to B2h.
// [RQ2] A write only lands while the password protection reports unlocked.
// [RQ3] Each accepted write blanks over/undervoltage monitoring for 5 ms.
// [RQ4] Bit 7 is the pulse-skip enable, read-write, reset one.
// [RQ5] Bits 5..0 are the voltage code: 25 mV steps to 1.550 V, then 50 mV to 3.400 V.
// [RQ6] Software must not program codes 35h to 3Fh, which have no voltage.
// [RQ7] Software should change the code only while the converter is disabled.
// [RQ8] The code resets to 32h unless a strapped default is selected.
// [RQ9] Bit 6 is reserved, reads zero and ignores writes.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module bbs_setpoint #(
	parameter int BLANK_COUNT = bbs_pkg::BLANK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [bbs_pkg::ADDR_W-1:0] regAddr,
	input wire logic [bbs_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [bbs_pkg::DATA_W-1:0] regRdata,
	input wire logic writeUnlocked,
	input wire logic converterEnabled,
	input wire logic defaultSelectStrap,
	input wire logic [bbs_pkg::CODE_W-1:0] strapCode,
	output logic pulseSkipEnable,
	output logic [bbs_pkg::CODE_W-1:0] voltageCode,
	output logic [15:0] setpointMillivolts,
	output logic monitorBlank,
	output logic codeReserved,
	output logic codeChangedLive
);
	import bbs_pkg::*;
	if (BLANK_COUNT < 1) begin : gBadCount
		$error("BLANK_COUNT must be at least one");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic skip;
		logic [CODE_W-1:0] code;
		logic [DATA_W-1:0] rdata;
		logic [1:0] strapSync;
		logic [1:0] strapPrime;
		logic [1:0][CODE_W-1:0] strapCodeSync;
		logic strapLoaded;
		logic [15:0] mv;
		logic rsvd;
		logic live;
		logic blank;
	} bbs_state_t;
	bbs_state_t st_reg, st_next;
	logic acceptWrite;
	logic blanking;
	logic [15:0] mapMv;
	logic mapRsvd;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	bbs_blank_timer #(.COUNT(BLANK_COUNT)) uTimer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(acceptWrite),
		.blanking(blanking)
	);
	bbs_code_map uMap (
		.code(st_reg.code),
		.millivolts(mapMv),
		.reserved(mapRsvd)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		acceptWrite = regWrite && (regAddr == SETPOINT_ADDR) && writeUnlocked; // [RQ1] [RQ2]
		st_next.strapSync = {st_reg.strapSync[0], defaultSelectStrap};
		st_next.strapPrime = {st_reg.strapPrime[0], 1'b1};
		st_next.strapCodeSync = {st_reg.strapCodeSync[0], strapCode};
		// Strap taken once, when both synchroniser stages hold pin values
		if (!st_reg.strapLoaded && st_reg.strapPrime[1]) begin
			st_next.strapLoaded = 1'b1;
			if (st_reg.strapSync[1]) st_next.code = st_reg.strapCodeSync[1]; // [RQ8]
		end
		if (acceptWrite) begin
			// An early write wins over a later strap load
			st_next.strapLoaded = 1'b1;
			st_next.skip = regWdata[SKIP_BIT]; // [RQ4]
			st_next.code = regWdata[CODE_MSB:0]; // [RQ5]
			// Live change flagged for software to inspect
			if (converterEnabled && regWdata[CODE_MSB:0] != st_reg.code) st_next.live = 1'b1; // [RQ7]
		end
		if (regRead && regAddr == STATUS_ADDR && !(acceptWrite && converterEnabled))
			st_next.live = 1'b0;
		st_next.rdata = '0;
		if (regRead) begin
			if (regAddr == SETPOINT_ADDR) begin
				st_next.rdata[SKIP_BIT] = st_reg.skip;
				st_next.rdata[RSVD_BIT] = 1'b0; // [RQ9]
				st_next.rdata[CODE_MSB:0] = st_reg.code;
			end else if (regAddr == STATUS_ADDR) begin
				st_next.rdata[ST_BLANK_BIT] = blanking;
				st_next.rdata[ST_RSVD_BIT] = mapRsvd; // [RQ6]
				st_next.rdata[ST_LOCK_BIT] = writeUnlocked;
			end
		end
		st_next.mv = mapMv; // [RQ5]
		st_next.rsvd = mapRsvd; // [RQ6]
		st_next.blank = blanking || acceptWrite; // [RQ3]
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.skip <= SETPOINT_RESET[SKIP_BIT]; // [RQ1] [RQ4]
			st_reg.code <= CODE_DEFAULT; // [RQ8]
			st_reg.rdata <= '0;
			st_reg.strapSync <= '0;
			st_reg.strapPrime <= '0;
			st_reg.strapCodeSync <= '0;
			st_reg.strapLoaded <= 1'b0;
			st_reg.mv <= '0;
			st_reg.rsvd <= 1'b0;
			st_reg.live <= 1'b0;
			st_reg.blank <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign regRdata = st_reg.rdata;
	assign pulseSkipEnable = st_reg.skip;
	assign voltageCode = st_reg.code;
	assign setpointMillivolts = st_reg.mv;
	assign monitorBlank = st_reg.blank;
	assign codeReserved = st_reg.rsvd;
	assign codeChangedLive = st_reg.live;
endmodule : bbs_setpoint

// ===== tb/bbs_setpoint_chk.sv
// Port checks for the buck-boost setpoint register.
// Assumes binding into bbs_setpoint.
`timescale 1ns/100ps
module bbs_setpoint_chk (
	input logic clk_sys,
	input logic rst_n,
	input logic [7:0] regAddr,
	input logic [7:0] regWdata,
	input logic regWrite,
	input logic regRead,
	input logic [7:0] regRdata,
	input logic writeUnlocked,
	input logic pulseSkipEnable,
	input logic [5:0] voltageCode,
	input logic [15:0] setpointMillivolts,
	input logic monitorBlank,
	input logic converterEnabled,
	input logic codeReserved,
	input logic codeChangedLive
);
	logic acc;
	logic [15:0] mvExp;
	assign acc = regWrite && regAddr == 8'h19 && writeUnlocked;
	assign mvExp = voltageCode < 6'h10 ? 16'h0497 + 16'h0019 * voltageCode :
		16'h0320 + 16'h0032 * voltageCode;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_reset_value: assert property (
		!$past(rst_n) |-> pulseSkipEnable && voltageCode == 6'h32) else $error("bad reset");
	a_write_lands: assert property (
		acc |=> {pulseSkipEnable, 1'b0, voltageCode} == ($past(regWdata) & 8'hBF))
		else $error("lost write");
	a_locked_hold: assert property (
		regWrite && !writeUnlocked |=> $stable(voltageCode)) else $error("locked write");
	a_blank_start: assert property (
		acc |=> monitorBlank [*8]) else $error("no blanking");
	a_blank_cause: assert property (
		$rose(monitorBlank) |-> $past(acc)) else $error("stray blanking");
	a_read_data: assert property (
		$past(regRead) && $past(regAddr) == 8'h19 |->
		regRdata == {$past(pulseSkipEnable), 1'b0, $past(voltageCode)})
		else $error("bad read");
	a_mv_map: assert property (
		$past(rst_n) && $past(voltageCode) < 6'h35 |-> setpointMillivolts == $past(mvExp))
		else $error("bad mv");
	a_rsvd_flag: assert property (
		$past(rst_n) |-> codeReserved == ($past(voltageCode) > 6'h34))
		else $error("bad reserved flag");
	a_live_cause: assert property (
		$rose(codeChangedLive) |-> $past(acc && converterEnabled && regWdata[5:0] != voltageCode))
		else $error("stray live flag");
	c_write: cover property (acc);
	c_locked: cover property (regWrite && !writeUnlocked);
	c_blank_end: cover property ($fell(monitorBlank));
endmodule : bbs_setpoint_chk
bind bbs_setpoint bbs_setpoint_chk chk (.clk_sys, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
	.regRdata, .writeUnlocked, .pulseSkipEnable, .voltageCode, .setpointMillivolts, .monitorBlank,
	.converterEnabled, .codeReserved, .codeChangedLive);

// ===== tb/tb_top.sv
// Bench for the buck-boost setpoint register.
// Assumes the checker binds itself in.
`timescale 1ns/100ps
module tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic writeUnlocked = 1'b0, rdPend = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d, e;
	logic [7:0] q[$];
	logic converterEnabled = 1'b0, defaultSelectStrap = 1'b0;
	logic [5:0] strapCode = 6'h00;
	logic codeReserved, codeChangedLive;
	int num_errors = 0, compares = 0;
	always #10 clk_sys = ~clk_sys;
	bbs_setpoint #(.BLANK_COUNT(20)) uut (.clk_sys, .rst_n, .regAddr, .regWdata, .regWrite,
		.regRead, .regRdata, .writeUnlocked, .converterEnabled, .defaultSelectStrap,
		.strapCode, .pulseSkipEnable(), .voltageCode(), .setpointMillivolts(),
		.monitorBlank(), .codeReserved, .codeChangedLive);
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		if (!w) q.push_back(v);
		regAddr <= a;
		regWdata <= v;
		regWrite <= w;
		regRead <= !w;
		@(posedge clk_sys);
	endtask : bus
	task automatic check_flag(input string n, input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s exp %b seen %b", n, exp, seen);
		end
	endtask : check_flag
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		if (rdPend) begin
			e = q.pop_front();
			compares++;
			if (regRdata !== e) begin
				num_errors++;
				$display("unexpected regRdata exp %h seen %h", e, regRdata);
			end
		end
		rdPend <= regRead;
	end
	initial begin
		#20000;
		num_errors++;
		print_verdict();
	end
	initial begin
		void'($urandom(72));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b0, 8'h19, 8'hB2);
		bus(1'b1, 8'h19, 8'h05);
		bus(1'b0, 8'h19, 8'hB2);
		bus(1'b0, 8'h1C, 8'h00);
		writeUnlocked <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			d = 8'($urandom);
			if (i < 2) d[5:0] = i ? 6'h34 : 6'h0F;
			if (d[5:0] > 6'h34) d[5:0] = d[5:0] - 6'h10;
			bus(1'b1, 8'h19, d);
			bus(1'b0, 8'h19, d & 8'hBF);
		end
		bus(1'b1, 8'h19, 8'h74);
		repeat (2) bus(1'b0, 8'h55, 8'h00);
		bus(1'b0, 8'h1C, 8'h05);
		bus(1'b1, 8'h18, 8'h00);
		converterEnabled <= 1'b1;
		bus(1'b1, 8'h19, 8'hB4);
		bus(1'b0, 8'h19, 8'hB4);
		converterEnabled <= 1'b0;
		check_flag("codeChangedLive", codeChangedLive, 1'b0);
		check_flag("codeReserved", codeReserved, 1'b0);
		repeat (30) bus(1'b0, 8'h19, 8'hB4);
		bus(1'b0, 8'h1C, 8'h04);
		regRead <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		defaultSelectStrap <= 1'b1;
		strapCode <= 6'h1A;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, 8'h19, 8'h9A);
		regRead <= 1'b0;
		repeat (2) @(posedge clk_sys);
		print_verdict();
	end
endmodule : tb_top
